// *** src/coef_cfg_handler.sv ***
module coef_cfg_handler
	import coef_cfg_pkg::*;
#(
	parameter int SEC_CYCLES = SECOND_CYCLES
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	// Received frame bytes, check bytes already verified and removed
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_VALID_IN,
	input wire logic RX_END_IN,
	// Reply bytes
	input wire logic TX_READY_IN,
	output logic [7:0] TX_DATA_OUT,
	output logic TX_VALID_OUT,
	output logic TX_LAST_OUT,
	// Device state
	input wire logic [7:0] DEV_ADDR_IN,
	input wire logic INIT_DONE_IN,
	input wire logic [1:0] PRESSURE_PRESENT_IN,
	input wire logic [2:0] TEMP_PRESENT_IN,
	// Raw measurements
	input wire logic MEAS_VALID_IN,
	input wire logic [VAL_W-1:0] CALC_RAW_IN,
	input wire logic [VAL_W-1:0] P1_RAW_IN,
	input wire logic [VAL_W-1:0] P2_RAW_IN,
	// Scaled measurements
	output logic SCALED_VALID_OUT,
	output logic [VAL_W-1:0] CALC_SCALED_OUT,
	output logic [VAL_W-1:0] P1_SCALED_OUT,
	output logic [VAL_W-1:0] P2_SCALED_OUT,
	// Configuration effects
	output logic [7:0] CALC_FUNC_OUT,
	output logic TEMP_MEAS_STB_OUT,
	output logic TEMP_COMP_STB_OUT,
	// Coefficient write event
	output logic COEF_WR_STB_OUT,
	output logic [7:0] COEF_WR_NUM_OUT,
	output logic [VAL_W-1:0] COEF_WR_DATA_OUT
);

	function automatic logic coef_writable(input logic [7:0] nr);
		coef_writable = (nr == K_THRESHOLD) || (nr >= K_SCALE_FIRST && nr <= K_SWITCH1_LAST) ||
			(nr == K_SWITCH2_HI) || (nr == K_SWITCH2_LO) || (nr >= K_FREE_FIRST && nr <= K_FREE_LAST);
	endfunction

	function automatic logic [LEN_W-1:0] frame_len(input logic [7:0] fn);
		case (fn)
			FN_WRITE_COEF: frame_len = LEN_WRITE_COEF;
			FN_READ_CFG: frame_len = LEN_READ_CFG;
			FN_WRITE_CFG: frame_len = LEN_WRITE_CFG;
			default: frame_len = LEN_NONE;
		endcase
	endfunction

	// Reset release
	logic rst_meta_q, rst_sync_q, rst_n;

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_n = rst_sync_q;

	// Frame state
	state_e state_q, state_d;
	logic [7:0] rx_buf_q [FRAME_MAX], rx_buf_d [FRAME_MAX];
	logic [LEN_W-1:0] rx_len_q, rx_len_d;
	logic [7:0] tx_buf_q [REPLY_LEN], tx_buf_d [REPLY_LEN];
	logic [1:0] tx_idx_q, tx_idx_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic tx_valid_q, tx_valid_d;
	logic tx_last_q, tx_last_d;
	logic [VAL_W-1:0] coef_q [SCALE_SLOTS], coef_d [SCALE_SLOTS];
	logic [7:0] calc_func_q, calc_func_d;
	logic [7:0] interval_q, interval_d;
	logic [7:0] comp_lp_q, comp_lp_d;
	logic wr_stb_q, wr_stb_d;
	logic [7:0] wr_num_q, wr_num_d;
	logic [VAL_W-1:0] wr_data_q, wr_data_d;

	// Decode of a finished frame
	logic [7:0] fn, nr, exc, reply_data;
	logic [VAL_W-1:0] coef_val;
	logic addr_ok, known, reply_en, ok;
	logic [7:0] active_p, active_t;

	always_comb begin
		fn = rx_buf_q[POS_FN];
		nr = rx_buf_q[POS_NR];
		coef_val = {rx_buf_q[POS_B3], rx_buf_q[POS_B2], rx_buf_q[POS_B1], rx_buf_q[POS_B0]};
		active_p = '0;
		active_p[ACT_P1_BIT] = PRESSURE_PRESENT_IN[0];
		active_p[ACT_P2_BIT] = PRESSURE_PRESENT_IN[1];
		active_t = '0;
		active_t[ACT_T_BIT] = TEMP_PRESENT_IN[0];
		active_t[ACT_FIRST_SENSOR_TEMPERATURE_BIT] = TEMP_PRESENT_IN[1];
		active_t[ACT_SECOND_SENSOR_TEMPERATURE_BIT] = TEMP_PRESENT_IN[2];
		addr_ok = (rx_len_q > LEN_W'(POS_ADDR)) &&
			(rx_buf_q[POS_ADDR] == DEV_ADDR_IN || rx_buf_q[POS_ADDR] == ADDR_TRANSPARENT);
		known = (rx_len_q > LEN_W'(POS_FN)) && (frame_len(fn) != LEN_NONE);
		reply_en = addr_ok && known;
		exc = REPLY_OK_BYTE;
		if (!INIT_DONE_IN)
			exc = EXC_NOT_INIT;
		else if (rx_len_q != frame_len(fn))
			exc = EXC_BAD_LENGTH;
		else if (fn == FN_WRITE_COEF && !coef_writable(nr))
			exc = EXC_BAD_NUMBER;
		else if (fn != FN_WRITE_COEF && nr > CFG_LAST_ENTRY)
			exc = EXC_BAD_NUMBER;
		ok = (exc == REPLY_OK_BYTE);
		reply_data = REPLY_OK_BYTE;
		if (!ok)
			reply_data = exc;
		else if (fn == FN_READ_CFG) begin
			case (nr)
				CFG_ACTIVE_PRESSURE: reply_data = active_p;
				CFG_ACTIVE_TEMP: reply_data = active_t;
				CFG_CALC_FUNC: reply_data = calc_func_q;
				CFG_TEMP_INTERVAL: reply_data = interval_q;
				CFG_COMP_LOWPASS: reply_data = comp_lp_q;
				default: reply_data = REPLY_OK_BYTE;
			endcase
		end
	end

	always_comb begin
		state_d = state_q;
		rx_buf_d = rx_buf_q;
		rx_len_d = rx_len_q;
		tx_buf_d = tx_buf_q;
		tx_idx_d = tx_idx_q;
		tx_data_d = tx_data_q;
		tx_valid_d = tx_valid_q;
		tx_last_d = tx_last_q;
		coef_d = coef_q;
		calc_func_d = calc_func_q;
		interval_d = interval_q;
		comp_lp_d = comp_lp_q;
		wr_stb_d = 1'b0;
		wr_num_d = wr_num_q;
		wr_data_d = wr_data_q;
		case (state_q)
			ST_RX: begin
				if (RX_VALID_IN) begin
					if (rx_len_q < LEN_W'(FRAME_MAX))
						rx_buf_d[rx_len_q[2:0]] = RX_DATA_IN;
					if (rx_len_q != LEN_SAT)
						rx_len_d = rx_len_q + 1'b1;
				end
				if (RX_END_IN) begin
					rx_len_d = '0;
					if (reply_en) begin
						state_d = ST_TX;
						tx_buf_d[0] = rx_buf_q[POS_ADDR];
						tx_buf_d[1] = ok ? fn : (fn | EXC_FLAG);
						tx_buf_d[2] = reply_data;
						tx_data_d = rx_buf_q[POS_ADDR];
						tx_valid_d = 1'b1;
						tx_last_d = 1'b0;
						tx_idx_d = 2'd1;
						if (ok && fn == FN_WRITE_COEF) begin
							wr_stb_d = 1'b1;
							wr_num_d = nr;
							wr_data_d = coef_val;
							if (nr >= K_SCALE_FIRST && nr < K_SCALE_FIRST + 8'(SCALE_SLOTS))
								coef_d[3'(nr - K_SCALE_FIRST)] = coef_val;
						end
						if (ok && fn == FN_WRITE_CFG) begin
							// Entries 0 and 1 and unused entries keep their value
							case (nr)
								CFG_CALC_FUNC: calc_func_d = rx_buf_q[POS_CFG_DATA];
								CFG_TEMP_INTERVAL: interval_d = rx_buf_q[POS_CFG_DATA];
								CFG_COMP_LOWPASS: comp_lp_d = rx_buf_q[POS_CFG_DATA];
								default: calc_func_d = calc_func_q;
							endcase
						end
					end
				end
			end
			ST_TX: begin
				// Half duplex: received bytes are dropped while replying
				if (TX_READY_IN) begin
					if (tx_last_q) begin
						tx_valid_d = 1'b0;
						tx_last_d = 1'b0;
						state_d = ST_RX;
					end else begin
						tx_data_d = tx_buf_q[tx_idx_q];
						tx_last_d = (tx_idx_q == 2'(REPLY_LEN - 1));
						tx_idx_d = tx_idx_q + 1'b1;
					end
				end
			end
			default: state_d = ST_RX;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RX;
			rx_len_q <= '0;
			tx_idx_q <= '0;
			tx_data_q <= '0;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
			calc_func_q <= RST_CALC_FUNC;
			interval_q <= RST_TEMP_INTERVAL;
			comp_lp_q <= RST_COMP_LOWPASS;
			wr_stb_q <= 1'b0;
			wr_num_q <= '0;
			wr_data_q <= '0;
			for (int i = 0; i < FRAME_MAX; i++)
				rx_buf_q[i] <= '0;
			for (int i = 0; i < REPLY_LEN; i++)
				tx_buf_q[i] <= '0;
			// Even slots are offsets, odd slots are gains
			for (int i = 0; i < SCALE_SLOTS; i++)
				coef_q[i] <= (i % 2 == 1) ? FIX_ONE : FIX_ZERO;
		end else begin
			state_q <= state_d;
			rx_len_q <= rx_len_d;
			tx_idx_q <= tx_idx_d;
			tx_data_q <= tx_data_d;
			tx_valid_q <= tx_valid_d;
			tx_last_q <= tx_last_d;
			calc_func_q <= calc_func_d;
			interval_q <= interval_d;
			comp_lp_q <= comp_lp_d;
			wr_stb_q <= wr_stb_d;
			wr_num_q <= wr_num_d;
			wr_data_q <= wr_data_d;
			rx_buf_q <= rx_buf_d;
			tx_buf_q <= tx_buf_d;
			coef_q <= coef_d;
		end
	end

	// Temperature measurement and compensation timing
	logic [31:0] sec_cnt_q, sec_cnt_d;
	logic [7:0] meas_sec_q, meas_sec_d;
	logic [NIBBLE_W-1:0] comp_cnt_q, comp_cnt_d;
	logic meas_stb_q, meas_stb_d, comp_stb_q, comp_stb_d;
	logic [NIBBLE_W-1:0] mult;

	always_comb begin
		mult = comp_lp_q[MULT_LSB +: NIBBLE_W];
		sec_cnt_d = sec_cnt_q + 1'b1;
		meas_sec_d = meas_sec_q;
		comp_cnt_d = comp_cnt_q;
		meas_stb_d = 1'b0;
		comp_stb_d = 1'b0;
		if (sec_cnt_q == 32'(SEC_CYCLES - 1)) begin
			sec_cnt_d = '0;
			if (interval_q == '0)
				meas_sec_d = '0;
			else if (meas_sec_q + 1'b1 >= interval_q) begin
				meas_sec_d = '0;
				meas_stb_d = 1'b1;
				if (mult == '0)
					comp_cnt_d = '0;
				else if (comp_cnt_q + 1'b1 >= mult) begin
					comp_cnt_d = '0;
					comp_stb_d = 1'b1;
				end else
					comp_cnt_d = comp_cnt_q + 1'b1;
			end else
				meas_sec_d = meas_sec_q + 1'b1;
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_q <= '0;
			meas_sec_q <= '0;
			comp_cnt_q <= '0;
			meas_stb_q <= 1'b0;
			comp_stb_q <= 1'b0;
		end else begin
			sec_cnt_q <= sec_cnt_d;
			meas_sec_q <= meas_sec_d;
			comp_cnt_q <= comp_cnt_d;
			meas_stb_q <= meas_stb_d;
			comp_stb_q <= comp_stb_d;
		end
	end

	// Channel scaling; only the two pressure channels are low-pass filtered
	logic [VAL_W-1:0] raw [CHANNELS];
	logic [VAL_W-1:0] scaled [CHANNELS];
	logic [CHANNELS-1:0] scaled_vld;

	assign raw[CH_CALC] = CALC_RAW_IN;
	assign raw[CH_P1] = P1_RAW_IN;
	assign raw[CH_P2] = P2_RAW_IN;

	generate
		for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
			localparam int OFS = (ch == CH_CALC) ? IDX_OFS_CALC : (ch == CH_P1) ? IDX_OFS_P1 : IDX_OFS_P2;
			channel_scaler #(
				.W(VAL_W),
				.FRAC(FRAC_BITS),
				.FILTER(ch != CH_CALC)
			) u_scaler (
				.clk_in(CLK_IN),
				.rst_n_in(rst_n),
				.sample_in(MEAS_VALID_IN),
				.raw_in(raw[ch]),
				.gain_in(coef_q[OFS + 1]),
				.offset_in(coef_q[OFS]),
				.lp_exp_in(comp_lp_q[LP_LSB +: NIBBLE_W]),
				.value_out(scaled[ch]),
				.valid_out(scaled_vld[ch])
			);
		end
	endgenerate

	assign TX_DATA_OUT = tx_data_q;
	assign TX_VALID_OUT = tx_valid_q;
	assign TX_LAST_OUT = tx_last_q;
	assign SCALED_VALID_OUT = scaled_vld[CH_CALC];
	assign CALC_SCALED_OUT = scaled[CH_CALC];
	assign P1_SCALED_OUT = scaled[CH_P1];
	assign P2_SCALED_OUT = scaled[CH_P2];
	assign CALC_FUNC_OUT = calc_func_q;
	assign TEMP_MEAS_STB_OUT = meas_stb_q;
	assign TEMP_COMP_STB_OUT = comp_stb_q;
	assign COEF_WR_STB_OUT = wr_stb_q;
	assign COEF_WR_NUM_OUT = wr_num_q;
	assign COEF_WR_DATA_OUT = wr_data_q;

endmodule

// *** pkg/coef_cfg_pkg.sv ***
package coef_cfg_pkg;

	// Frame handler states, one-hot
	typedef enum logic [1:0] {
		ST_RX = 2'b01,
		ST_TX = 2'b10
	} state_e;

	// Function codes and reply markers
	localparam logic [7:0] FN_WRITE_COEF = 8'h1f;
	localparam logic [7:0] FN_READ_CFG = 8'h20;
	localparam logic [7:0] FN_WRITE_CFG = 8'h21;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_BAD_NUMBER = 8'h02;
	localparam logic [7:0] EXC_BAD_LENGTH = 8'h03;
	localparam logic [7:0] EXC_NOT_INIT = 8'h20;
	localparam logic [7:0] REPLY_OK_BYTE = 8'h00;
	localparam logic [7:0] ADDR_TRANSPARENT = 8'hfa;

	// Frame lengths without the two check bytes
	localparam int LEN_W = 4;
	localparam logic [LEN_W-1:0] LEN_SAT = 4'hf;
	localparam logic [LEN_W-1:0] LEN_NONE = 4'h0;
	localparam logic [LEN_W-1:0] LEN_WRITE_COEF = 4'h7;
	localparam logic [LEN_W-1:0] LEN_READ_CFG = 4'h3;
	localparam logic [LEN_W-1:0] LEN_WRITE_CFG = 4'h4;
	localparam int FRAME_MAX = 8;
	localparam int REPLY_LEN = 3;

	// Byte positions inside a received frame
	localparam int POS_ADDR = 0;
	localparam int POS_FN = 1;
	localparam int POS_NR = 2;
	localparam int POS_CFG_DATA = 3;
	localparam int POS_B3 = 3;
	localparam int POS_B2 = 4;
	localparam int POS_B1 = 5;
	localparam int POS_B0 = 6;

	// Configuration entry numbers
	localparam logic [7:0] CFG_ACTIVE_PRESSURE = 8'h00;
	localparam logic [7:0] CFG_ACTIVE_TEMP = 8'h01;
	localparam logic [7:0] CFG_CALC_FUNC = 8'h02;
	localparam logic [7:0] CFG_TEMP_INTERVAL = 8'h03;
	localparam logic [7:0] CFG_COMP_LOWPASS = 8'h04;
	localparam logic [7:0] CFG_LAST_ENTRY = 8'h0d;

	// Field positions of the read-only entries and of entry 4
	localparam int ACT_P1_BIT = 1;
	localparam int ACT_P2_BIT = 2;
	localparam int ACT_T_BIT = 3;
	localparam int ACT_FIRST_SENSOR_TEMPERATURE_BIT = 4;
	localparam int ACT_SECOND_SENSOR_TEMPERATURE_BIT = 5;
	localparam int MULT_LSB = 0;
	localparam int LP_LSB = 4;
	localparam int NIBBLE_W = 4;

	// Reset values of the writable entries
	localparam logic [7:0] RST_CALC_FUNC = 8'h00;
	localparam logic [7:0] RST_TEMP_INTERVAL = 8'h01;
	localparam logic [7:0] RST_COMP_LOWPASS = 8'h01;
	localparam logic [7:0] CALC_INACTIVE = 8'h00;

	// Coefficient numbers
	localparam logic [7:0] K_THRESHOLD = 8'h35;
	localparam logic [7:0] K_SCALE_FIRST = 8'h40;
	localparam logic [7:0] K_SWITCH1_LAST = 8'h49;
	localparam logic [7:0] K_SWITCH2_HI = 8'h4e;
	localparam logic [7:0] K_SWITCH2_LO = 8'h4f;
	localparam logic [7:0] K_FREE_FIRST = 8'h64;
	localparam logic [7:0] K_FREE_LAST = 8'h6f;
	localparam int SCALE_SLOTS = 8;
	localparam int IDX_OFS_P1 = 0;
	localparam int IDX_OFS_P2 = 2;
	localparam int IDX_OFS_CALC = 6;

	// Scaling arithmetic in signed fixed point
	localparam int VAL_W = 32;
	localparam int FRAC_BITS = 16;
	localparam logic [VAL_W-1:0] FIX_ONE = 32'h0001_0000;
	localparam logic [VAL_W-1:0] FIX_ZERO = 32'h0000_0000;
	localparam int CHANNELS = 3;
	localparam int CH_CALC = 0;
	localparam int CH_P1 = 1;
	localparam int CH_P2 = 2;

	// Timing
	localparam longint SECOND_NS = 1000000000;
	localparam longint CLK_PERIOD_NS = 10;
	localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage

// *** src/channel_scaler.sv ***
module channel_scaler
	import coef_cfg_pkg::*;
#(
	parameter int W = VAL_W,
	parameter int FRAC = FRAC_BITS,
	parameter bit FILTER = 1'b0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Sample and coefficients
	input wire logic sample_in,
	input wire logic signed [W-1:0] raw_in,
	input wire logic signed [W-1:0] gain_in,
	input wire logic signed [W-1:0] offset_in,
	input wire logic [NIBBLE_W-1:0] lp_exp_in,
	// Scaled result
	output logic signed [W-1:0] value_out,
	output logic valid_out
);

	localparam int AW = W + (1 << NIBBLE_W);

	logic signed [W-1:0] filt_q, filt_d;
	logic primed_q, primed_d;
	logic stage_q, stage_d;
	logic signed [W-1:0] val_q, val_d;
	logic vld_q, vld_d;
	logic signed [AW-1:0] acc;
	logic signed [2*W-1:0] prod;

	always_comb begin
		filt_d = filt_q;
		primed_d = primed_q;
		stage_d = sample_in;
		acc = (AW'(filt_q) <<< lp_exp_in) - AW'(filt_q) + AW'(raw_in);
		if (sample_in) begin
			primed_d = 1'b1;
			// First sample seeds the filter so it does not ramp up from zero
			if (!FILTER || !primed_q)
				filt_d = raw_in;
			else
				filt_d = W'(acc >>> lp_exp_in);
		end
		prod = gain_in * filt_q;
		val_d = val_q;
		if (stage_q)
			val_d = W'(prod >>> FRAC) + offset_in;
		vld_d = stage_q;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			filt_q <= '0;
			primed_q <= 1'b0;
			stage_q <= 1'b0;
			val_q <= '0;
			vld_q <= 1'b0;
		end else begin
			filt_q <= filt_d;
			primed_q <= primed_d;
			stage_q <= stage_d;
			val_q <= val_d;
			vld_q <= vld_d;
		end
	end

	assign value_out = val_q;
	assign valid_out = vld_q;

endmodule

// *** tb/coef_cfg_handler_assertions.sv ***
module coef_cfg_checker
	import coef_cfg_pkg::*;
#(
	parameter int SEC_CYCLES = SECOND_CYCLES
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	// Frame and reply
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_VALID_IN,
	input wire logic RX_END_IN,
	input wire logic TX_READY_IN,
	input wire logic [7:0] TX_DATA_OUT,
	input wire logic TX_VALID_OUT,
	input wire logic TX_LAST_OUT,
	// Device state and events
	input wire logic [7:0] DEV_ADDR_IN,
	input wire logic INIT_DONE_IN,
	input wire logic MEAS_VALID_IN,
	input wire logic SCALED_VALID_OUT,
	input wire logic TEMP_MEAS_STB_OUT,
	input wire logic TEMP_COMP_STB_OUT,
	input wire logic COEF_WR_STB_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	logic [LEN_W-1:0] cnt_q, fc_q;
	logic [7:0] a_q, fn_q, nr_q, fa_q, ff_q, fnr_q;
	logic fi_q;
	logic last_q;
	// Shadow of the frame that is being received, latched when it ends
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			{cnt_q, fc_q, a_q, fn_q, nr_q, fa_q, ff_q, fnr_q, fi_q} <= '0;
		end else if (!TX_VALID_OUT) begin
			if (RX_VALID_IN) begin
				cnt_q <= (cnt_q == LEN_SAT) ? cnt_q : cnt_q + 4'h1;
				if (cnt_q == 4'h0) a_q <= RX_DATA_IN;
				if (cnt_q == 4'h1) fn_q <= RX_DATA_IN;
				if (cnt_q == 4'h2) nr_q <= RX_DATA_IN;
			end
			if (RX_END_IN) begin
				{cnt_q, fc_q, fa_q, ff_q, fnr_q, fi_q} <= {4'h0, cnt_q, a_q, fn_q, nr_q, INIT_DONE_IN};
			end
		end
	end
	assign last_q = TX_VALID_OUT && TX_LAST_OUT;
	tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
		else $error("reply byte changed before it was taken");
	reply_start_a: assert property ($rose(TX_VALID_OUT) |-> $past(RX_END_IN) && TX_DATA_OUT == fa_q
		&& (fa_q == DEV_ADDR_IN || fa_q == ADDR_TRANSPARENT)) else $error("reply start or echo wrong");
	foreign_quiet_a: assert property (RX_END_IN && !TX_VALID_OUT && a_q != DEV_ADDR_IN
		&& a_q != ADDR_TRANSPARENT |=> !TX_VALID_OUT [*8]) else $error("reply to a foreign address");
	not_init_a: assert property (last_q && !fi_q |-> TX_DATA_OUT == EXC_NOT_INIT)
		else $error("missing not-initialised code");
	bad_len_a: assert property (last_q && fi_q && ff_q == FN_WRITE_COEF && fc_q != LEN_WRITE_COEF
		|-> TX_DATA_OUT == EXC_BAD_LENGTH) else $error("missing length code");
	bad_entry_a: assert property (last_q && fi_q && ff_q == FN_READ_CFG && fc_q == LEN_READ_CFG
		&& fnr_q > CFG_LAST_ENTRY |-> TX_DATA_OUT == EXC_BAD_NUMBER) else $error("missing entry code");
	cfg_wr_ok_a: assert property (last_q && fi_q && ff_q == FN_WRITE_CFG && fc_q == LEN_WRITE_CFG
		&& fnr_q <= CFG_LAST_ENTRY |-> TX_DATA_OUT == REPLY_OK_BYTE) else $error("write reply not zero");
	coef_stb_a: assert property (COEF_WR_STB_OUT |-> $rose(TX_VALID_OUT) && ff_q == FN_WRITE_COEF && fi_q)
		else $error("coefficient strobe without write");
	scaled_lat_a: assert property (MEAS_VALID_IN |-> ##2 SCALED_VALID_OUT)
		else $error("scaled result late");
	comp_meas_a: assert property (TEMP_COMP_STB_OUT |-> TEMP_MEAS_STB_OUT)
		else $error("compensation off the interval");
endmodule

bind coef_cfg_handler coef_cfg_checker #(.SEC_CYCLES(SEC_CYCLES)) u_coef_cfg_checker (
	.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .RX_DATA_IN(RX_DATA_IN), .RX_VALID_IN(RX_VALID_IN),
	.RX_END_IN(RX_END_IN), .TX_READY_IN(TX_READY_IN), .TX_DATA_OUT(TX_DATA_OUT), .TX_VALID_OUT(TX_VALID_OUT),
	.TX_LAST_OUT(TX_LAST_OUT), .DEV_ADDR_IN(DEV_ADDR_IN), .INIT_DONE_IN(INIT_DONE_IN),
	.MEAS_VALID_IN(MEAS_VALID_IN), .SCALED_VALID_OUT(SCALED_VALID_OUT), .TEMP_MEAS_STB_OUT(TEMP_MEAS_STB_OUT),
	.TEMP_COMP_STB_OUT(TEMP_COMP_STB_OUT), .COEF_WR_STB_OUT(COEF_WR_STB_OUT));

// *** tb/coef_cfg_master.sv ***
module coef_cfg_master (
	// Clock
	input wire logic clk_in,
	// Frame to the device and reply acceptance
	output logic [7:0] rx_data_out = 8'h00,
	output logic rx_valid_out = 1'b0,
	output logic rx_end_out = 1'b0,
	output logic tx_ready_out = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	// Sink stalls at random
	always @(negedge clk_in) tx_ready_out <= 1'($urandom_range(0, 1));
	// Bytes back to back, then the end marker; idle data is scrambled
	task automatic send(input logic [7:0] f [8], input int len);
		for (int i = 0; i < len; i++) begin
			@(negedge clk_in);
			rx_valid_out <= 1'b1;
			rx_data_out <= f[i];
		end
		@(negedge clk_in);
		rx_valid_out <= 1'b0;
		rx_end_out <= 1'b1;
		rx_data_out <= ~rx_data_out;
		@(negedge clk_in);
		rx_end_out <= 1'b0;
	endtask
	// Output range coefficients, pressures given in bar
	function automatic logic [31:0] range_gain(input real k92, k93, a, b);
		return 32'(longint'((k93 - k92) / (b - a) * 65536.0));
	endfunction
	// Lower end of the output range from the stored offset and gain
	function automatic real range_low(input real k92, k68, k69);
		return (k92 - k68) / k69;
	endfunction
	function automatic logic [31:0] range_ofs(input real k92, k93, a, b);
		return 32'(longint'((k92 - (k93 - k92) / (b - a) * a) * 65536.0));
	endfunction
endmodule

// *** tb/coef_cfg_handler_tb.sv ***
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module coef_cfg_handler_tb
	import coef_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SEC = 10;
	logic CLK_IN, RESET_N_IN, RX_VALID_IN, RX_END_IN, TX_READY_IN, TX_VALID_OUT, TX_LAST_OUT, INIT_DONE_IN;
	logic MEAS_VALID_IN, SCALED_VALID_OUT, TEMP_MEAS_STB_OUT, TEMP_COMP_STB_OUT, COEF_WR_STB_OUT;
	logic [7:0] RX_DATA_IN, TX_DATA_OUT, DEV_ADDR_IN, CALC_FUNC_OUT, COEF_WR_NUM_OUT;
	logic [1:0] PRESSURE_PRESENT_IN;
	logic [2:0] TEMP_PRESENT_IN;
	logic [VAL_W-1:0] CALC_RAW_IN, P1_RAW_IN, P2_RAW_IN, CALC_SCALED_OUT, P1_SCALED_OUT, P2_SCALED_OUT;
	logic [VAL_W-1:0] COEF_WR_DATA_OUT;
	logic [8:0] exp_q [$];
	logic [39:0] cq [$];
	logic [95:0] sq [$];
	logic [8:0] e;
	logic [39:0] ec;
	logic [95:0] es;
	int n_mismatch = 0;
	int n_tests = 0;
	longint g [3], o [3], filt [3];
	logic [7:0] good [8] = '{8'h35, 8'h40, 8'h45, 8'h49, 8'h4e, 8'h4f, 8'h64, 8'h6f};
	logic [7:0] bad [9] = '{8'h34, 8'h36, 8'h3f, 8'h4a, 8'h4d, 8'h50, 8'h63, 8'h70, 8'hff};
	logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
	logic [7:0] gn [3] = '{8'h47, 8'h41, 8'h43};
	logic [7:0] on [3] = '{8'h46, 8'h40, 8'h42};

	coef_cfg_handler #(.SEC_CYCLES(SEC)) u_coef_cfg_handler (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
		.RX_DATA_IN(RX_DATA_IN), .RX_VALID_IN(RX_VALID_IN), .RX_END_IN(RX_END_IN), .TX_READY_IN(TX_READY_IN),
		.TX_DATA_OUT(TX_DATA_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_LAST_OUT(TX_LAST_OUT),
		.DEV_ADDR_IN(DEV_ADDR_IN), .INIT_DONE_IN(INIT_DONE_IN), .PRESSURE_PRESENT_IN(PRESSURE_PRESENT_IN),
		.TEMP_PRESENT_IN(TEMP_PRESENT_IN), .MEAS_VALID_IN(MEAS_VALID_IN), .CALC_RAW_IN(CALC_RAW_IN),
		.P1_RAW_IN(P1_RAW_IN), .P2_RAW_IN(P2_RAW_IN), .SCALED_VALID_OUT(SCALED_VALID_OUT),
		.CALC_SCALED_OUT(CALC_SCALED_OUT), .P1_SCALED_OUT(P1_SCALED_OUT), .P2_SCALED_OUT(P2_SCALED_OUT),
		.CALC_FUNC_OUT(CALC_FUNC_OUT), .TEMP_MEAS_STB_OUT(TEMP_MEAS_STB_OUT), .TEMP_COMP_STB_OUT(TEMP_COMP_STB_OUT),
		.COEF_WR_STB_OUT(COEF_WR_STB_OUT), .COEF_WR_NUM_OUT(COEF_WR_NUM_OUT), .COEF_WR_DATA_OUT(COEF_WR_DATA_OUT));
	coef_cfg_master u_coef_cfg_master (.clk_in(CLK_IN), .rx_data_out(RX_DATA_IN), .rx_valid_out(RX_VALID_IN),
		.rx_end_out(RX_END_IN), .tx_ready_out(TX_READY_IN));

	initial begin
		CLK_IN = 1'b0;
		forever #5 CLK_IN = ~CLK_IN;
	end

	// Results are taken in the cycle they appear and matched to the oldest note
	always @(posedge CLK_IN) begin
		if (TX_VALID_OUT === 1'b1 && TX_READY_IN === 1'b1) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
			`CHK({TX_LAST_OUT, TX_DATA_OUT}, e)
		end
		if (COEF_WR_STB_OUT === 1'b1) begin
			ec = (cq.size() != 0) ? cq.pop_front() : 'x;
			`CHK({COEF_WR_NUM_OUT, COEF_WR_DATA_OUT}, ec)
		end
		if (SCALED_VALID_OUT === 1'b1) begin
			es = (sq.size() != 0) ? sq.pop_front() : 'x;
			`CHK({CALC_SCALED_OUT, P1_SCALED_OUT, P2_SCALED_OUT}, es)
		end
	end

	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic xfer(input logic [7:0] a, fn, nr, input logic [31:0] d, input int len,
		input logic [7:0] rfn, rd, input bit reply);
		logic [7:0] f [8];
		int k;
		f = '{a, fn, nr, (fn == FN_WRITE_CFG) ? d[7:0] : d[31:24], d[23:16], d[15:8], d[7:0], 8'h5a};
		if (reply) begin
			exp_q.push_back({1'b0, a});
			exp_q.push_back({1'b0, rfn});
			exp_q.push_back({1'b1, rd});
		end
		u_coef_cfg_master.send(f, len);
		for (k = 0; k < 300 && exp_q.size() != 0; k++) @(negedge CLK_IN);
		if (k == 300) begin
			n_mismatch++;
			print_verdict();
		end
		repeat (4) @(negedge CLK_IN);
	endtask
	task automatic rd_cfg(input logic [7:0] nr, v);
		xfer(DEV_ADDR_IN, FN_READ_CFG, nr, 32'h0, 3, FN_READ_CFG, v, 1'b1);
	endtask
	task automatic wr_cfg(input logic [7:0] nr, v);
		xfer(DEV_ADDR_IN, FN_WRITE_CFG, nr, {24'h0, v}, 4, FN_WRITE_CFG, REPLY_OK_BYTE, 1'b1);
	endtask
	task automatic wr_coef(input logic [7:0] nr, input logic [31:0] v);
		cq.push_back({nr, v});
		xfer(DEV_ADDR_IN, FN_WRITE_COEF, nr, v, 7, FN_WRITE_COEF, REPLY_OK_BYTE, 1'b1);
	endtask
	task automatic exc(input logic [7:0] fn, nr, input int len, input logic [7:0] code);
		xfer(DEV_ADDR_IN, fn, nr, $urandom, len, fn | EXC_FLAG, code, 1'b1);
	endtask
	task automatic meas(input int n);
		longint r [3];
		for (int i = 0; i < 3; i++) begin
			r[i] = longint'($urandom_range(0, 32'h1f_ffff)) - 32'sh10_0000;
			filt[i] = (i == CH_CALC) ? r[i] : (((filt[i] <<< n) - filt[i] + r[i]) >>> n);
		end
		sq.push_back({32'(g[0] * filt[0] + o[0]), 32'(g[1] * filt[1] + o[1]), 32'(g[2] * filt[2] + o[2])});
		@(negedge CLK_IN);
		{MEAS_VALID_IN, CALC_RAW_IN, P1_RAW_IN, P2_RAW_IN} <= {1'b1, 32'(r[0]), 32'(r[1]), 32'(r[2])};
		@(negedge CLK_IN);
		MEAS_VALID_IN <= 1'b0;
		repeat (3) @(negedge CLK_IN);
	endtask
	// Spacing between the first and second strobe of one kind
	task automatic gap(input bit comp, input int want);
		int k;
		for (int n = 0; n < 2; n++) begin
			for (k = 1; k < 500; k++) begin
				@(negedge CLK_IN);
				if ((comp ? TEMP_COMP_STB_OUT : TEMP_MEAS_STB_OUT) === 1'b1) break;
			end
		end
		`CHK(k, want)
		if (k >= 500) print_verdict();
	endtask

	initial begin
		{RESET_N_IN, INIT_DONE_IN, MEAS_VALID_IN, CALC_RAW_IN, P1_RAW_IN, P2_RAW_IN} = '0;
		void'($urandom(91959));
		DEV_ADDR_IN = 8'($urandom_range(1, 248));
		PRESSURE_PRESENT_IN = 2'($urandom_range(0, 3));
		TEMP_PRESENT_IN = 3'($urandom_range(0, 7));
		repeat (8) @(negedge CLK_IN);
		RESET_N_IN = 1'b1;
		repeat (4) @(negedge CLK_IN);
		exc(FN_READ_CFG, CFG_TEMP_INTERVAL, 3, EXC_NOT_INIT);
		exc(FN_WRITE_COEF, K_THRESHOLD, 7, EXC_NOT_INIT);
		INIT_DONE_IN = 1'b1;
		for (int i = 0; i < 2; i++) begin
			rd_cfg(CFG_ACTIVE_PRESSURE, {5'h0, PRESSURE_PRESENT_IN, 1'b0});
			rd_cfg(CFG_ACTIVE_TEMP, {2'h0, TEMP_PRESENT_IN, 3'h0});
			wr_cfg(CFG_ACTIVE_PRESSURE, 8'hff);
			wr_cfg(CFG_ACTIVE_TEMP, 8'hff);
		end
		rd_cfg(CFG_CALC_FUNC, RST_CALC_FUNC);
		rd_cfg(CFG_TEMP_INTERVAL, RST_TEMP_INTERVAL);
		rd_cfg(CFG_COMP_LOWPASS, RST_COMP_LOWPASS);
		rd_cfg(CFG_LAST_ENTRY, 8'h00);
		exc(FN_READ_CFG, CFG_LAST_ENTRY + 8'h01, 3, EXC_BAD_NUMBER);
		exc(FN_WRITE_CFG, 8'hff, 4, EXC_BAD_NUMBER);
		exc(FN_READ_CFG, CFG_CALC_FUNC, 4, EXC_BAD_LENGTH);
		exc(FN_WRITE_CFG, CFG_CALC_FUNC, 3, EXC_BAD_LENGTH);
		exc(FN_WRITE_COEF, K_SCALE_FIRST, 6, EXC_BAD_LENGTH);
		exc(FN_WRITE_COEF, K_SCALE_FIRST, 8, EXC_BAD_LENGTH);
		xfer(DEV_ADDR_IN + 8'h01, FN_READ_CFG, CFG_ACTIVE_PRESSURE, 32'h0, 3, 8'h00, 8'h00, 1'b0);
		xfer(DEV_ADDR_IN, 8'h1e, K_SCALE_FIRST, 32'h0, 3, 8'h00, 8'h00, 1'b0);
		xfer(ADDR_TRANSPARENT, FN_READ_CFG, CFG_TEMP_INTERVAL, 32'h0, 3, FN_READ_CFG, RST_TEMP_INTERVAL, 1'b1);
		foreach (good[i]) wr_coef(good[i], $urandom);
		foreach (bad[i]) exc(FN_WRITE_COEF, bad[i], 7, EXC_BAD_NUMBER);
		wr_coef(K_THRESHOLD, FIX_ONE);
		foreach (codes[i]) begin
			wr_cfg(CFG_CALC_FUNC, codes[i]);
			rd_cfg(CFG_CALC_FUNC, codes[i]);
			`CHK(CALC_FUNC_OUT, codes[i])
		end
		for (int i = 0; i < 3; i++) begin
			g[i] = longint'($urandom_range(0, 4)) - 64'sh2;
			o[i] = longint'($urandom_range(0, 32'hffff)) - 32'sh8000;
			wr_coef(gn[i], 32'(g[i] <<< 16));
			wr_coef(on[i], 32'(o[i]));
		end
		meas(0);
		meas(0);
		wr_cfg(CFG_COMP_LOWPASS, 8'h21);
		meas(2);
		meas(2);
		wr_coef(8'h45, u_coef_cfg_master.range_gain(0.0, 10.0, 1.0, 6.0));
		wr_coef(8'h44, u_coef_cfg_master.range_ofs(0.0, 10.0, 1.0, 6.0));
		`CHK(int'(u_coef_cfg_master.range_low(0.0, real'($signed(COEF_WR_DATA_OUT)) / 65536.0, 2.0)), 1)
		wr_cfg(CFG_TEMP_INTERVAL, 8'h02);
		wr_cfg(CFG_COMP_LOWPASS, 8'h03);
		gap(1'b0, 2 * SEC);
		gap(1'b1, 6 * SEC);
		`CHK(exp_q.size() + cq.size() + sq.size(), 0)
		print_verdict();
	end
endmodule
